// >>> hw/usb_ep0_flags.sv
// endpoint 0 flags, interrupt gating and ep0 transmit control
// assumes a serial engine on mclk giving token, ack and rx pulses,
// and D+/D- pin levels that are asynchronous to mclk
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module usb_ep0_flags #(
  parameter int RESET_CYC = usb_ep0_pkg::SE0_RESET_CYC, // se0 length for bus reset
  parameter int EOP_CYC   = usb_ep0_pkg::SE0_EOP_CYC    // se0 length for eop
) (
  input  wire logic                mclk,          // system clock
  input  wire logic                rst_b,         // async reset, low
  input  wire logic                ce,            // clock enable
  input  wire logic                hsel,          // ahb select
  input  wire logic [31:0]         haddr,         // ahb address
  input  wire logic [1:0]          htrans,        // ahb transfer type
  input  wire logic                hwrite,        // ahb write
  input  wire logic [2:0]          hsize,         // ahb size
  input  wire logic [31:0]         hwdata,        // ahb write data
  input  wire logic                hready,        // ahb ready in
  output logic      [31:0]         hrdata,        // ahb read data
  output logic                     hreadyout,     // ahb ready out
  output logic                     hresp,         // ahb response
  input  wire logic                dpPin,         // D+ level
  input  wire logic                dmPin,         // D- level
  input  wire logic                tokenValid,    // token received pulse
  input  wire usb_ep0_pkg::tok_e   tokenPid,      // token kind
  input  wire logic [3:0]          tokenEp,       // token endpoint
  input  wire logic                hostAck,       // host ack after our data
  input  wire logic                rxPacketOk,    // good data packet received
  output logic                     respValid,     // answer pulse
  output usb_ep0_pkg::resp_e       respCode,      // answer kind
  output logic                     respDataPid,   // 0 DATA0, 1 DATA1
  output logic      [3:0]          respByteCount, // bytes to send
  output logic                     usbClkEnable,  // usb module clock gate
  output logic                     usbSuspend,    // usb module suspend
  output logic                     sysResetReq,   // system reset pulse
  output logic                     cpuIrq         // cpu interrupt level
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RESET_CYC < 2 || RESET_CYC > 511 || EOP_CYC < 1 || EOP_CYC >= RESET_CYC) begin : g_bad
    $error("usb_ep0_flags: se0 counts out of range");
  end

  // ----------------------------------------------------------------
  // decode helper
  // ----------------------------------------------------------------
  // true when a byte address selects the register of a given index
  function automatic logic hitIdx(input logic [31:0] a, input logic [7:0] idx);
    hitIdx = (a[31:10] == 22'h000000) && (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LINE_IDLE, LINE_SE0, LINE_RESET} line_e;

  line_e      line_reg;            // bus line state
  logic [8:0] se0Cnt_reg;          // se0 length counter
  logic [7:0] flags_reg;           // interrupt flags
  logic [7:0] enables_reg;         // interrupt enables
  logic [7:0] ep0Ctl_reg;          // ep0 transmit control
  logic       ep12En_reg;          // ep1/2 transmit enable
  logic       wrPend_reg;          // write data phase pending
  logic [7:0] wrIdx_reg;           // index of pending write
  logic       wrHit_reg;           // pending write is mapped
  logic       pendEp0In_reg;       // data sent on ep0, waiting ack
  logic       pendEp12In_reg;      // data sent on ep1/2, waiting ack
  logic       pendEp0Out_reg;      // ep0 out/setup accepted
  logic       softRst_reg;         // bus reset with system reset enabled
  logic [1:0] pinSync;             // synchronised D+, inverted D-

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     ({dpPin, !dmPin}),    // D- inverted so the reset value reads as idle J
    .q     (pinSync)
  );

  // ----------------------------------------------------------------
  // line decode
  // ----------------------------------------------------------------
  wire        lineDp     = pinSync[1];                 // synchronised D+
  wire        lineDm     = !pinSync[0];                // synchronised D-, inversion undone
  wire        lineSe0    = !lineDp && !lineDm;         // both low
  wire        lineJ      = lineDm && !lineDp;          // low speed idle
  wire [8:0]  resetLast  = 9'(RESET_CYC - 1);          // count at detection
  wire [8:0]  eopLeast   = 9'(EOP_CYC);                // least eop length
  wire        busResetEvt = lineSe0 && (line_reg == LINE_SE0)
                            && (se0Cnt_reg == resetLast);
  wire        eopEvt     = lineJ && (line_reg == LINE_SE0)
                            && (se0Cnt_reg >= eopLeast);
  wire        activityEvt = !lineJ && flags_reg[usb_ep0_pkg::BIT_SUSPEND];

  // ----------------------------------------------------------------
  // ahb decode
  // ----------------------------------------------------------------
  wire        addrPhase  = hsel && htrans[1] && hready;   // transfer taken
  wire        rdPhase    = addrPhase && !hwrite;          // read taken
  wire        rdFlags    = rdPhase && hitIdx(haddr, usb_ep0_pkg::IDX_INTERRUPT_FLAGS);
  wire        rdEnables  = rdPhase && hitIdx(haddr, usb_ep0_pkg::IDX_INTERRUPT_ENABLES);
  wire        rdEp0Ctl   = rdPhase && hitIdx(haddr, usb_ep0_pkg::IDX_EP0_TX_CONTROL);
  wire        rdEp12Ctl  = rdPhase && hitIdx(haddr, usb_ep0_pkg::IDX_EP12_TX_CONTROL);
  wire [7:0]  ep12View   = {2'h0, ep12En_reg, 5'h00};     // only the enable reads back
  wire [7:0]  rdByte     = rdFlags   ? flags_reg   :
                           rdEnables ? enables_reg :
                           rdEp0Ctl  ? ep0Ctl_reg  :
                           rdEp12Ctl ? ep12View    : 8'h00;
  wire [7:0]  wrByte     = hwdata[7:0];                   // narrow data in low lane
  wire        wrGo       = wrPend_reg && wrHit_reg;
  wire        wrFlags    = wrGo && (wrIdx_reg == usb_ep0_pkg::IDX_INTERRUPT_FLAGS);
  wire        wrEnables  = wrGo && (wrIdx_reg == usb_ep0_pkg::IDX_INTERRUPT_ENABLES);
  wire        wrEp0Ctl   = wrGo && (wrIdx_reg == usb_ep0_pkg::IDX_EP0_TX_CONTROL);
  wire        wrEp12Ctl  = wrGo && (wrIdx_reg == usb_ep0_pkg::IDX_EP12_TX_CONTROL);
  wire        wrMapped   = hitIdx(haddr, usb_ep0_pkg::IDX_INTERRUPT_FLAGS)
                           || hitIdx(haddr, usb_ep0_pkg::IDX_INTERRUPT_ENABLES)
                           || hitIdx(haddr, usb_ep0_pkg::IDX_EP0_TX_CONTROL)
                           || hitIdx(haddr, usb_ep0_pkg::IDX_EP12_TX_CONTROL);

  // ----------------------------------------------------------------
  // token decode and answer selection
  // ----------------------------------------------------------------
  wire        suspended  = flags_reg[usb_ep0_pkg::BIT_SUSPEND];
  wire        tokTake    = tokenValid && !suspended;          // engine frozen in suspend
  wire        tokEp0     = (tokenEp == 4'h0);
  wire        tokEp12    = (tokenEp == 4'h1) || (tokenEp == 4'h2);
  wire        isIn       = (tokenPid == usb_ep0_pkg::TOK_IN);
  wire        isOut      = (tokenPid == usb_ep0_pkg::TOK_OUT);
  wire        isSetup    = (tokenPid == usb_ep0_pkg::TOK_SETUP);
  wire        ep0_force_stall     = ep0Ctl_reg[usb_ep0_pkg::BIT_STALL];
  wire        txEn0      = ep0Ctl_reg[usb_ep0_pkg::BIT_TX_EN];
  wire        rxEn0      = ep0Ctl_reg[usb_ep0_pkg::BIT_RX_EN];
  wire        txDone0    = flags_reg[usb_ep0_pkg::BIT_EP0_TX];
  wire        rxDone0    = flags_reg[usb_ep0_pkg::BIT_EP0_RX];
  wire        txDone12   = flags_reg[usb_ep0_pkg::BIT_EP12_TX];
  wire        ep0InNak   = !txEn0 || txDone0;
  wire        ep0OutNak  = !rxEn0 || rxDone0;
  wire        ep12InNak  = !ep12En_reg || txDone12;
  wire        sendEp0    = tokTake && tokEp0 && isIn && !ep0_force_stall && !ep0InNak;
  wire        takeEp0    = tokTake && tokEp0 && ((isOut && !ep0_force_stall && !ep0OutNak) || isSetup);
  wire        sendEp12   = tokTake && tokEp12 && isIn && !ep12InNak;
  wire        setupClr   = tokTake && tokEp0 && isSetup;

  usb_ep0_pkg::resp_e respNext;                               // answer for this token
  assign respNext = !(tokTake && (tokEp0 || (tokEp12 && isIn))) ? usb_ep0_pkg::RESP_NONE :
                    (tokEp0 && isSetup)                  ? usb_ep0_pkg::RESP_ACK   :
                    (tokEp0 && (isIn || isOut) && ep0_force_stall) ? usb_ep0_pkg::RESP_STALL :
                    (sendEp0 || sendEp12)                ? usb_ep0_pkg::RESP_DATA  :
                    takeEp0                              ? usb_ep0_pkg::RESP_ACK   :
                    (tokEp0 && !isIn && !isOut)          ? usb_ep0_pkg::RESP_NONE  :
                                                           usb_ep0_pkg::RESP_NAK;

  // ----------------------------------------------------------------
  // flag next values, a hardware set beats a written clear
  // ----------------------------------------------------------------
  wire        ep0TxSet   = hostAck && pendEp0In_reg;
  wire        ep0RxSet   = rxPacketOk && pendEp0Out_reg;
  wire        ep12TxSet  = hostAck && pendEp12In_reg;
  wire [7:0]  hwSet      = {2'b00, busResetEvt, ep0TxSet, ep0RxSet, ep12TxSet,
                            eopEvt, activityEvt};
  wire [7:0]  swClr      = wrFlags ? ~wrByte : 8'h00;         // write zero clears
  wire [7:0]  keepMask   = softRst_reg ? 8'h20 : 8'hFF;       // system reset spares bus reset
  wire        susNext    = softRst_reg ? 1'b0 :
                           wrFlags ? wrByte[usb_ep0_pkg::BIT_SUSPEND] : suspended;
  wire        rstfNext   = busResetEvt
                           || (flags_reg[usb_ep0_pkg::BIT_BUS_RESET] && !rdFlags);
  wire [4:0]  lowFlags   = hwSet[4:0] | (flags_reg[4:0] & ~swClr[4:0] & keepMask[4:0]);
  wire [7:0]  flags_next = {susNext, 1'b0, rstfNext, lowFlags};

  // ----------------------------------------------------------------
  // ep0 control next value
  // ----------------------------------------------------------------
  wire [7:0]  ctlWritten = wrEp0Ctl ? wrByte : ep0Ctl_reg;
  wire [7:0]  stallMask  = setupClr ? 8'hBF : 8'hFF;          // setup clears stall
  wire [7:0]  ep0Ctl_next = softRst_reg ? usb_ep0_pkg::RST_EP0_CTL
                                        : (ctlWritten & stallMask);

  // ----------------------------------------------------------------
  // interrupt gating
  // ----------------------------------------------------------------
  wire [7:0]  irqMask    = enables_reg & 8'hBF;               // reset-enable is no source
  wire        irqNext    = |(flags_next & irqMask);

  // ----------------------------------------------------------------
  // line state machine and se0 counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      line_reg   <= LINE_IDLE;
      se0Cnt_reg <= 9'h000;
    end else if (ce) begin
      case (line_reg)
        LINE_IDLE: begin
          se0Cnt_reg <= 9'h000;
          if (lineSe0) begin
            line_reg <= LINE_SE0;
          end
        end
        LINE_SE0: begin
          // count se0 length, end of se0 decides eop or not
          if (!lineSe0) begin
            line_reg <= LINE_IDLE;
          end else if (busResetEvt) begin
            line_reg <= LINE_RESET;
          end else begin
            se0Cnt_reg <= se0Cnt_reg + 9'h001;
          end
        end
        LINE_RESET: begin
          // hold until the line leaves se0, no eop reported
          if (!lineSe0) begin
            line_reg <= LINE_IDLE;
          end
        end
        default: begin
          line_reg <= LINE_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ahb slave, zero wait, read data registered in the address phase
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg  <= 8'h00;
      wrHit_reg  <= 1'b0;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b0;
      hresp      <= 1'b0;
    end else if (ce) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wrPend_reg <= addrPhase && hwrite;
      wrIdx_reg  <= haddr[9:2];
      wrHit_reg  <= wrMapped;
      if (rdPhase) begin
        hrdata <= {24'h000000, rdByte};
      end
    end
  end

  // ----------------------------------------------------------------
  // registers that software writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg   <= usb_ep0_pkg::RST_FLAGS;
      enables_reg <= usb_ep0_pkg::RST_ENABLES;
      ep0Ctl_reg  <= usb_ep0_pkg::RST_EP0_CTL;
      ep12En_reg  <= 1'b0;
    end else if (ce) begin
      flags_reg  <= flags_next;
      ep0Ctl_reg <= ep0Ctl_next;
      if (wrEnables) begin
        enables_reg <= wrByte;
      end
      if (softRst_reg) begin
        ep12En_reg <= 1'b0;
      end else if (wrEp12Ctl) begin
        ep12En_reg <= wrByte[usb_ep0_pkg::BIT_EP12_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // transaction tracking and answers to the serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pendEp0In_reg  <= 1'b0;
      pendEp12In_reg <= 1'b0;
      pendEp0Out_reg <= 1'b0;
      respValid      <= 1'b0;
      respCode       <= usb_ep0_pkg::RESP_NONE;
      respDataPid    <= 1'b0;
      respByteCount  <= 4'h0;
    end else if (ce) begin
      respValid <= (respNext != usb_ep0_pkg::RESP_NONE);
      if (tokTake) begin
        // a new token ends any transaction still waiting
        respCode       <= respNext;
        respDataPid    <= ep0Ctl_reg[usb_ep0_pkg::BIT_TOGGLE];
        respByteCount  <= ep0Ctl_reg[usb_ep0_pkg::CNT_MSB:0];
        pendEp0In_reg  <= sendEp0;
        pendEp12In_reg <= sendEp12;
        pendEp0Out_reg <= takeEp0;
      end else if (hostAck || rxPacketOk || softRst_reg) begin
        pendEp0In_reg  <= 1'b0;
        pendEp12In_reg <= 1'b0;
        pendEp0Out_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // suspend, clock gate, system reset and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      usbClkEnable <= 1'b0;
      usbSuspend   <= 1'b0;
      softRst_reg  <= 1'b0;
      sysResetReq  <= 1'b0;
      cpuIrq       <= 1'b0;
    end else if (ce) begin
      usbClkEnable <= !flags_next[usb_ep0_pkg::BIT_SUSPEND];
      usbSuspend   <= flags_next[usb_ep0_pkg::BIT_SUSPEND];
      softRst_reg  <= busResetEvt && enables_reg[usb_ep0_pkg::BIT_RST_SYS];
      sysResetReq  <= busResetEvt && enables_reg[usb_ep0_pkg::BIT_RST_SYS];
      cpuIrq       <= irqNext;
    end
  end

endmodule

// >>> hw/usb_ep0_pkg.sv
// package for the endpoint 0 flag and transmit control block
// assumes a 125 MHz mclk and a word-wide AHB-Lite register port
package usb_ep0_pkg;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_INTERRUPT_FLAGS   = 8'hE8; // status flags
  localparam logic [7:0] IDX_INTERRUPT_ENABLES = 8'hE9; // enables
  localparam logic [7:0] IDX_EP0_TX_CONTROL    = 8'hEA; // ep0 control
  localparam logic [7:0] IDX_EP12_TX_CONTROL   = 8'hEB; // ep1/2 enable only

  // ----------------------------------------------------------------
  // bit positions, flags and enables share the same layout
  // ----------------------------------------------------------------
  localparam int BIT_SUSPEND   = 7; // suspend flag / enable
  localparam int BIT_RST_SYS   = 6; // enable only: bus reset resets system
  localparam int BIT_BUS_RESET = 5; // bus reset flag
  localparam int BIT_EP0_TX    = 4; // ep0 transmit done
  localparam int BIT_EP0_RX    = 3; // ep0 receive done
  localparam int BIT_EP12_TX   = 2; // ep1/2 transmit done
  localparam int BIT_EOP       = 1; // end of packet
  localparam int BIT_RESUME    = 0; // resume
  localparam int BIT_TOGGLE    = 7; // ep0 data toggle
  localparam int BIT_STALL     = 6; // ep0 force stall
  localparam int BIT_TX_EN     = 5; // ep0 transmit enable
  localparam int BIT_RX_EN     = 4; // ep0 receive enable
  localparam int BIT_EP12_EN   = 5; // ep1/2 transmit enable
  localparam int CNT_MSB       = 3; // ep0 byte count, bits 3..0

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_EP0_CTL = 8'h00;

  // ----------------------------------------------------------------
  // line timing at 125 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;  // mclk rate
  localparam int SE0_RESET_NS   = 2500; // least se0 for a bus reset
  localparam int SE0_EOP_NS     = 670;  // least se0 for an end of packet
  localparam int SE0_RESET_CYC  = (SE0_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int SE0_EOP_CYC    = (SE0_EOP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // token and answer kinds on the serial engine side
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP, TOK_SOF} tok_e;
  typedef enum logic [2:0] {RESP_NONE, RESP_NAK, RESP_STALL, RESP_ACK, RESP_DATA} resp_e;

endpackage

// >>> hw/pin_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
// assumes the caller reads only q, never the first stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_reg; // first stage, read only by q

  // two stages, frozen while ce is low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// >>> sim/usb_ep0_flags_assertions.sv
// port checker of the ep0 flag block, bound onto the design below
// assumes tokens are single-cycle pulses on mclk
`timescale 1ns/1ps
module usb_ep0_flags_assertions (
  input wire logic               mclk, rst_b, ce, tokenValid, respValid,
  input wire logic               usbSuspend, usbClkEnable, sysResetReq,
  input wire usb_ep0_pkg::tok_e  tokenPid,
  input wire logic [3:0]         tokenEp,
  input wire usb_ep0_pkg::resp_e respCode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire tk = tokenValid && ce && !usbSuspend; // token taken
  wire e0 = tk && tokenEp == 4'h0;           // taken, endpoint 0
  AST_CLK_GATE: assert property ($past(rst_b) |-> usbClkEnable != usbSuspend)
    else $error("usb clock gate does not follow suspend");
  AST_SUSP_TOK: assert property (tokenValid && usbSuspend ##1 usbSuspend |-> !respValid)
    else $error("token answered while suspended");
  AST_EP0_IN: assert property (e0 && tokenPid == usb_ep0_pkg::TOK_IN ##1 !usbSuspend |->
    respValid && respCode inside {usb_ep0_pkg::RESP_NAK, usb_ep0_pkg::RESP_STALL,
    usb_ep0_pkg::RESP_DATA}) else $error("bad answer to ep0 in");
  AST_EP0_OUT: assert property (e0 && tokenPid == usb_ep0_pkg::TOK_OUT ##1 !usbSuspend |->
    respValid && respCode inside {usb_ep0_pkg::RESP_NAK, usb_ep0_pkg::RESP_STALL,
    usb_ep0_pkg::RESP_ACK}) else $error("bad answer to ep0 out");
  AST_SETUP: assert property (e0 && tokenPid == usb_ep0_pkg::TOK_SETUP ##1 !usbSuspend |->
    respCode == usb_ep0_pkg::RESP_ACK) else $error("setup not acked");
  AST_FAR_EP: assert property (tk && tokenEp > 4'h2 |=> !respValid)
    else $error("unknown endpoint answered");
  AST_EP12_OUT: assert property (tk && tokenEp inside {4'h1, 4'h2} &&
    tokenPid != usb_ep0_pkg::TOK_IN |=> !respValid) else $error("ep1/2 non-in answered");
  AST_RESP_CAUSE: assert property (respValid |-> $past(tokenValid && ce))
    else $error("answer without token");
  AST_SYS_PULSE: assert property (sysResetReq |=> !sysResetReq)
    else $error("system reset longer than one cycle");
  cover property (e0 ##1 respCode == usb_ep0_pkg::RESP_DATA);
  cover property (sysResetReq);
  cover property ($rose(usbSuspend));
endmodule
bind usb_ep0_flags usb_ep0_flags_assertions u_chk (.*);

// >>> sim/usb_host_model.sv
// host side model: tokens, handshakes and D+/D- line states
// assumes one bench process calls its tasks at a time
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic         mclk,
  output logic              tokenValid, hostAck, rxPacketOk, dpPin, dmPin,
  output usb_ep0_pkg::tok_e tokenPid,
  output logic [3:0]        tokenEp
);
  // idle low-speed bus shows J, nothing pending
  initial begin
    {tokenValid, hostAck, rxPacketOk, dpPin, dmPin} = 5'b00001;
    tokenPid = usb_ep0_pkg::TOK_SOF;
    tokenEp = 4'h0;
  end
  // one token pulse; the endpoint field is scrambled once released
  task automatic tok(input usb_ep0_pkg::tok_e p, input logic [3:0] e);
    @(posedge mclk);
    {tokenValid, tokenEp} <= {1'b1, e};
    tokenPid <= p;
    @(posedge mclk);
    {tokenValid, tokenEp} <= {1'b0, ~e};
  endtask
  // handshake pulse: k low is host ack of data, k high a good packet
  task automatic hs(input logic k);
    @(posedge mclk);
    {rxPacketOk, hostAck} <= {k, !k};
    @(posedge mclk);
    {rxPacketOk, hostAck} <= 2'b00;
  endtask
  // hold a line state n cycles, then back to J (se0 then J is eop)
  task automatic line(input logic p, input logic m, input int n);
    @(posedge mclk);
    {dpPin, dmPin} <= {p, m};
    repeat (n) @(posedge mclk);
    {dpPin, dmPin} <= 2'b01;
  endtask
endmodule

// >>> sim/tb.sv
// bench: ahb-lite master and host model around the ep0 flag block
// assumes small se0 counts of 20 and 4 cycles
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
  logic mclk, rst_b, ce, hsel, hwrite, hreadyout, hresp, respValid, respDataPid, usbClkEnable;
  logic usbSuspend, sysResetReq, cpuIrq, tokenValid, hostAck, rxPacketOk, dpPin, dmPin;
  logic [31:0] haddr, hwdata, hrdata, q, seed;
  logic [7:0] c;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tokenEp, respByteCount;
  usb_ep0_pkg::tok_e tokenPid;
  usb_ep0_pkg::resp_e respCode;
  int fails, compares, pulses = 0;
  localparam logic [31:0] AFL = {22'h0, usb_ep0_pkg::IDX_INTERRUPT_FLAGS, 2'h0};
  localparam logic [31:0] AEN = {22'h0, usb_ep0_pkg::IDX_INTERRUPT_ENABLES, 2'h0};
  localparam logic [31:0] ACT = {22'h0, usb_ep0_pkg::IDX_EP0_TX_CONTROL, 2'h0};
  usb_ep0_flags #(.RESET_CYC(20), .EOP_CYC(4)) u_usb_ep0_flags (.hready(hreadyout), .*);
  usb_host_model u_usb_host_model (.*);
  // count system reset pulses seen
  always @(posedge mclk) pulses <= pulses + int'(sysResetReq);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected ep0 answer from control c, done flag d, o high for out
  function automatic usb_ep0_pkg::resp_e ex(input logic [7:0] c, input logic d, input logic o);
    if (c[6]) return usb_ep0_pkg::RESP_STALL;
    if (!c[o ? 4 : 5] || d) return usb_ep0_pkg::RESP_NAK;
    return o ? usb_ep0_pkg::RESP_ACK : usb_ep0_pkg::RESP_DATA;
  endfunction
  // one single transfer, read data left in q
  task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'h2};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'h0, 24'h0, d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // token, then look mid-cycle while the answer pulse stands
  task automatic tk(input usb_ep0_pkg::tok_e p, input logic [3:0] e);
    u_usb_host_model.tok(p, e);
    @(negedge mclk);
  endtask
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    {rst_b, ce, hsel, hwrite, htrans, haddr, hwdata, hsize} = {3'b010, 67'h0, 3'h2};
    {seed, fails, compares} = {32'h55, 64'h0};
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    bus(AFL, 0, 0); `CHK(q, 32'h0)
    bus(ACT, 0, 0); `CHK(q, 32'h0)
    bus(AFL + 32'h40, 0, 0); `CHK({q, hresp, usbClkEnable}, {32'h0, 2'b01})
    bus(AEN, 1, 8'h1B);
    repeat (6) begin
      c = xs() & 8'h8F | 8'h20;
      bus(ACT, 1, c); tk(usb_ep0_pkg::TOK_IN, 0); `CHK(respValid, 1'b1)
      `CHK({respCode, respDataPid, respByteCount}, {ex(c, 0, 0), c[7], c[3:0]})
    end
    u_usb_host_model.hs(0); bus(AFL, 0, 0); `CHK({q[4], cpuIrq}, 2'b11)
    tk(usb_ep0_pkg::TOK_IN, 0); `CHK(respCode, ex(c, 1, 0))
    bus(AFL, 1, 0); bus(ACT, 1, 0); tk(usb_ep0_pkg::TOK_IN, 0);
    `CHK({respCode, cpuIrq}, {ex(0, 0, 0), 1'b0})
    bus(ACT, 1, 8'h50); tk(usb_ep0_pkg::TOK_OUT, 0); `CHK(respCode, ex(8'h50, 0, 1))
    tk(usb_ep0_pkg::TOK_SETUP, 0); bus(ACT, 0, 0); `CHK(q[6], 1'b0)
    tk(usb_ep0_pkg::TOK_OUT, 0); `CHK(respCode, ex(8'h10, 0, 1))
    u_usb_host_model.hs(1); tk(usb_ep0_pkg::TOK_OUT, 0); `CHK(respCode, ex(8'h10, 1, 1))
    tk(usb_ep0_pkg::TOK_OUT, 1); `CHK(respValid, 1'b0)
    tk(usb_ep0_pkg::TOK_IN, 3); `CHK(respValid, 1'b0)
    bus(ACT + 32'h4, 1, 8'h20); tk(usb_ep0_pkg::TOK_IN, 2);
    `CHK(respCode, usb_ep0_pkg::RESP_DATA)
    u_usb_host_model.hs(0); tk(usb_ep0_pkg::TOK_IN, 1);
    `CHK(respCode, usb_ep0_pkg::RESP_NAK)
    u_usb_host_model.line(0, 0, 8); repeat (5) @(posedge mclk);
    bus(AFL, 0, 0); `CHK(q[3:1], 3'b111)
    bus(AFL, 1, 8'h80); @(posedge mclk); `CHK(usbSuspend, 1'b1)
    tk(usb_ep0_pkg::TOK_IN, 0); `CHK(respValid, 1'b0)
    u_usb_host_model.line(1, 0, 2); repeat (5) @(posedge mclk);
    bus(AFL, 0, 0); `CHK(q[7] & q[0], 1'b1)
    bus(AFL, 1, 0); bus(AEN, 1, 8'h60); bus(ACT, 1, 8'hA5);
    u_usb_host_model.line(0, 0, 30); repeat (5) @(posedge mclk);
    `CHK(cpuIrq, 1'b1)
    bus(AFL, 0, 0); `CHK(q[5], 1'b1)
    bus(ACT, 0, 0); `CHK(q, 32'h0)
    `CHK(pulses, 1)
    $display("all scenarios done");
    complete_run();
  end
endmodule
